// *** dorb_pkg.sv ***
package dorb_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_ERR_CODE   = 16'h603f;
  localparam logic [15:0] IDX_CMD_WORD   = 16'h6040;
  localparam logic [15:0] IDX_BAL_SET    = 16'h4100;
  localparam logic [15:0] IDX_BAL_LIMIT  = 16'h4101;
  localparam logic [15:0] IDX_BAL_HYST   = 16'h4102;
  localparam logic [15:0] IDX_BAL_STATE  = 16'h4103;
  localparam logic [15:0] IDX_BOOT_VER   = 16'h4110;
  localparam logic [15:0] IDX_BOOT_BUS   = 16'h4111;
  localparam logic [15:0] IDX_BOOT_HWGRP = 16'h4112;
  localparam logic [15:0] IDX_SUPPLY_MV  = 16'h4120;
  localparam logic [15:0] IDX_LOGIC_MV   = 16'h4121;
  localparam logic [15:0] IDX_BOARD_TEMP = 16'h4122;
  localparam logic [15:0] IDX_SERIAL     = 16'h4130;
  localparam logic [15:0] IDX_DEVICE_ID  = 16'h4131;
  localparam logic [15:0] IDX_IRQ_STAT   = 16'h4140;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'h4141;

  // ==========================================================================
  // Reset values and fields
  localparam logic [31:0] RST_BAL_SET   = 32'h0000_0001;
  localparam logic [31:0] RST_BAL_LIMIT = 32'h0000_c019;
  localparam logic [31:0] RST_BAL_HYST  = 32'h0000_01f4;
  localparam logic [15:0] RST_ERR_CODE  = 16'h0000;
  localparam logic [15:0] RST_CMD_WORD  = 16'h0000;
  localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
  localparam int BAL_EN_BIT   = 0;
  localparam int QSTOP_BIT    = 2;
  localparam int EV_BAL_ON    = 0;
  localparam int EV_BAL_OFF   = 1;
  localparam int EV_NEW_ERR   = 2;
  localparam int EV_PDO_CMD   = 3;
  localparam int EV_N         = 4;

  typedef enum logic [0:0] {
    BAL_OFF = 1'b0,
    BAL_ON  = 1'b1
  } dorb_bal_e;

  typedef struct packed {
    logic signed [31:0] supply_mv;
    logic signed [31:0] logic_mv;
    logic signed [31:0] board_temp_dc;
  } dorb_cond_s;

  typedef struct packed {
    logic [15:0]        error_code;
    dorb_cond_s         cond;
  } dorb_txpdo_s;

endpackage

// *** dorb_reg_bank.sv ***
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// - Supply and logic rail voltages read back as signed millivolt words.
// - Board temperature reads back as a signed word in tenths of a degree.
// - Ballast settings bit 0 enables the ballast and the word resets to one.
// - The ballast limit word holds the millivolt threshold and resets to 0000c019.
// - The ballast hysteresis word holds millivolts and resets to 000001f4.
// - All three ballast words are full 32-bit read-write registers.
// - Boot version reads main version in the upper half and minor in the lower half.
// - Boot fieldbus word reads a read-only mask of supported fieldbuses.
// - Error code mirrors the low 16 bits of the latest error field entry.
// - Error code is read-only, goes out in transmit process data, reads zero after reset.
// - Command word is read-write, loadable from receive process data, resets to zero.
// - Serial number is a read-only word kept out of process data.
// - Device identifier is a read-only word kept out of process data.
module dorb_reg_bank
  import dorb_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Measured conditions and identity
  input  wire dorb_cond_s          cond_in,
  input  wire logic [31:0]         boot_version_in,
  input  wire logic [31:0]         boot_fieldbus_in,
  input  wire logic [31:0]         boot_hwgroup_in,
  input  wire logic [31:0]         serial_in,
  input  wire logic [31:0]         device_id_in,
  // Error field
  input  wire logic                err_push,
  input  wire logic [31:0]         err_entry,
  // Receive process data
  input  wire logic                rxpdo_cmd_valid,
  input  wire logic [15:0]         rxpdo_cmd_word,
  // Outputs to the drive
  output logic [15:0]              cmd_word,
  output logic                     ballast_on,
  output dorb_txpdo_s              txpdo,
  output logic                     irq
);

  // ==========================================================================
  // Write channel capture
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_full_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_full_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              wr_go;
  logic [15:0]       wr_idx;
  logic              wr_ok;

  assign wr_go  = aw_full_r && w_full_r && !bvalid_r;
  assign wr_idx = aw_addr_r[17:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && !aw_full_r) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && !w_full_r) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (wr_idx)
      IDX_CMD_WORD, IDX_BAL_SET, IDX_BAL_LIMIT, IDX_BAL_HYST, IDX_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction

  // ==========================================================================
  // Ballast configuration words
  logic [31:0] bal_set_r;
  logic [31:0] bal_limit_r;
  logic [31:0] bal_hyst_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bal_set_r   <= RST_BAL_SET;
      bal_limit_r <= RST_BAL_LIMIT;
      bal_hyst_r  <= RST_BAL_HYST;
    end else if (wr_go) begin
      if (wr_idx == IDX_BAL_SET)   bal_set_r   <= merge(bal_set_r, w_data_r, w_strb_r);
      if (wr_idx == IDX_BAL_LIMIT) bal_limit_r <= merge(bal_limit_r, w_data_r, w_strb_r);
      if (wr_idx == IDX_BAL_HYST)  bal_hyst_r  <= merge(bal_hyst_r, w_data_r, w_strb_r);
    end
  end

  // ==========================================================================
  // Command word
  logic [15:0] cmd_r;
  logic [31:0] cmd_merged;

  assign cmd_merged = merge({16'h0000, cmd_r}, w_data_r, w_strb_r);

  // A bus write and a process-data load in the same cycle: the process data wins,
  // since it is the cyclic source the drive follows.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= RST_CMD_WORD;
    end else if (rxpdo_cmd_valid) begin
      cmd_r <= rxpdo_cmd_word;
    end else if (wr_go && wr_idx == IDX_CMD_WORD) begin
      cmd_r <= cmd_merged[15:0];
    end
  end
  assign cmd_word = cmd_r;

  // ==========================================================================
  // Error code mirror
  logic [15:0] err_code_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_code_r <= RST_ERR_CODE;
    end else if (err_push) begin
      err_code_r <= err_entry[15:0];
    end
  end

  // ==========================================================================
  // Ballast hysteresis comparator
  dorb_bal_e         bal_st_r;
  logic signed [33:0] v_sup;
  logic signed [33:0] v_on;
  logic signed [33:0] v_off;

  assign v_sup = 34'(cond_in.supply_mv);
  assign v_on  = $signed({2'b00, bal_limit_r});
  assign v_off = $signed({2'b00, bal_limit_r}) - $signed({2'b00, bal_hyst_r});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bal_st_r <= BAL_OFF;
    end else if (!bal_set_r[BAL_EN_BIT]) begin
      bal_st_r <= BAL_OFF;
    end else begin
      unique case (bal_st_r)
        BAL_OFF: if (v_sup > v_on)  bal_st_r <= BAL_ON;
        BAL_ON:  if (v_sup < v_off) bal_st_r <= BAL_OFF;
      endcase
    end
  end
  assign ballast_on = (bal_st_r == BAL_ON);

  // ==========================================================================
  // Interrupt status, mask and output
  logic [EV_N-1:0] irq_stat_r;
  logic [EV_N-1:0] irq_mask_r;
  logic [EV_N-1:0] ev;
  logic            irq_r;
  logic            bal_prev_r;
  logic            stat_rd;

  always_ff @(posedge aclk) begin
    if (!aresetn) bal_prev_r <= 1'b0;
    else          bal_prev_r <= ballast_on;
  end

  always_comb begin
    ev             = '0;
    ev[EV_BAL_ON]  = ballast_on && !bal_prev_r;
    ev[EV_BAL_OFF] = !ballast_on && bal_prev_r;
    ev[EV_NEW_ERR] = err_push;
    ev[EV_PDO_CMD] = rxpdo_cmd_valid;
  end

  // A read clears the status, but an event in that same cycle stays set.
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat_r <= '0;
    else          irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (wr_go && wr_idx == IDX_IRQ_MASK && w_strb_r[0]) begin
      irq_mask_r <= w_data_r[EV_N-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_r <= 1'b0;
    else          irq_r <= |(((stat_rd ? '0 : irq_stat_r) | ev) & irq_mask_r);
  end
  assign irq = irq_r;

  // ==========================================================================
  // Transmit process data image
  dorb_txpdo_s txpdo_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txpdo_r <= '0;
    end else begin
      txpdo_r.error_code <= err_code_r;
      txpdo_r.cond       <= cond_in;
    end
  end
  assign txpdo = txpdo_r;

  // ==========================================================================
  // Read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_nxt;
  logic        rd_hit;
  logic [15:0] rd_idx;
  logic        rd_go;

  assign rd_go   = s_axi_arvalid && !rvalid_r;
  assign rd_idx  = s_axi_araddr[17:2];
  assign stat_rd = rd_go && rd_idx == IDX_IRQ_STAT;

  always_comb begin
    rd_nxt = '0;
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_ERR_CODE:   rd_nxt = {16'h0000, err_code_r};
      IDX_CMD_WORD:   rd_nxt = {16'h0000, cmd_r};
      IDX_BAL_SET:    rd_nxt = bal_set_r;
      IDX_BAL_LIMIT:  rd_nxt = bal_limit_r;
      IDX_BAL_HYST:   rd_nxt = bal_hyst_r;
      IDX_BAL_STATE:  rd_nxt = {31'h0, ballast_on};
      IDX_BOOT_VER:   rd_nxt = boot_version_in;
      IDX_BOOT_BUS:   rd_nxt = boot_fieldbus_in;
      IDX_BOOT_HWGRP: rd_nxt = boot_hwgroup_in;
      IDX_SUPPLY_MV:  rd_nxt = cond_in.supply_mv;
      IDX_LOGIC_MV:   rd_nxt = cond_in.logic_mv;
      IDX_BOARD_TEMP: rd_nxt = cond_in.board_temp_dc;
      IDX_SERIAL:     rd_nxt = serial_in;
      IDX_DEVICE_ID:  rd_nxt = device_id_in;
      IDX_IRQ_STAT:   rd_nxt = {28'h0, irq_stat_r};
      IDX_IRQ_MASK:   rd_nxt = {28'h0, irq_mask_r};
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_nxt;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_full_r && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_full_r && !s_axi_wready;
      s_axi_arready <= rd_go;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bal_on_edge: assert property (
    bal_set_r[BAL_EN_BIT] && !ballast_on && v_sup > v_on |=> ballast_on)
    else $error("ballast did not switch on above limit");
  a_bal_off_edge: assert property (
    ballast_on && v_sup < v_off |=> !ballast_on)
    else $error("ballast did not switch off below limit minus hysteresis");
  a_bal_disabled: assert property (
    !bal_set_r[BAL_EN_BIT] |=> !ballast_on)
    else $error("ballast on while disabled");
  a_err_mirror: assert property (
    err_push |=> err_code_r == $past(err_entry[15:0]) ##1 txpdo.error_code == $past(err_entry[15:0], 2))
    else $error("error code mirror wrong");
  a_err_hold: assert property (
    !err_push |=> $stable(err_code_r))
    else $error("error code changed without an entry");
  a_cmd_pdo: assert property (
    rxpdo_cmd_valid |=> cmd_word == $past(rxpdo_cmd_word))
    else $error("command word not loaded from process data");
  a_cmd_qstop: assert property (
    $fell(cmd_word[QSTOP_BIT]) |-> $past(rxpdo_cmd_valid) || $past(wr_go && wr_idx == IDX_CMD_WORD))
    else $error("quick stop bit cleared by hardware");
  a_cfg_writes: assert property (
    wr_go && wr_idx == IDX_BAL_LIMIT && w_strb_r == 4'hf |=> bal_limit_r == $past(w_data_r))
    else $error("ballast limit write lost");
  a_ro_write: assert property (
    wr_go && (wr_idx == IDX_SERIAL || wr_idx == IDX_ERR_CODE) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("write to read-only word accepted");
  a_rd_answer: assert property (
    rd_go && rd_idx == IDX_BOOT_VER |=> s_axi_rvalid && s_axi_rdata == $past(boot_version_in))
    else $error("boot version read wrong");

  c_bal_cycle: cover property (ballast_on ##[1:50] !ballast_on);
  c_pdo_cmd:   cover property (rxpdo_cmd_valid ##1 irq);
  c_rd_stat:   cover property (stat_rd ##1 s_axi_rvalid);

endmodule // dorb_reg_bank

// *** dorb_axi_master.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Fieldbus master stand-in; it tolerates answer latency and waits at most 64 cycles.
module dorb_axi_master
  import dorb_pkg::*;
(
  // Clock
  input  wire logic              aclk,
  // Write channels
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [DATA_W-1:0]      wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  // Read channels
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  int timeouts = 0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Released addresses and write data are inverted so that stale values are never trusted; wstrb stays set.
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wready === 1'b1) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) timeouts++;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    d = '0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) timeouts++;
  endtask
endmodule // dorb_axi_master

// *** tb_drive_object_register_bank.sv ***
`timescale 1ns/1ns
module tb_drive_object_register_bank
  import dorb_pkg::*;
;
  // ==========================================================================
  // Signals
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, err_push, pdo_v, ballast_on, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic [31:0]       err_entry;
  logic [15:0]       pdo_w, cmd_word;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rr;
  dorb_cond_s        cond;
  dorb_txpdo_s       txpdo;
  int                miscompares = 0;
  int                checked = 0;
  localparam logic [31:0] V_BOOT = 32'h0004_0002;
  localparam logic [31:0] V_BUS  = 32'h0000_0005;
  localparam logic [31:0] V_HW   = 32'h0000_0003;
  // Serial and identifier values are arbitrary.
  localparam logic [31:0] V_SER  = 32'h1357_9bdf;
  localparam logic [31:0] V_DID  = 32'h0000_00a5;
  logic [15:0] ri [11] = '{IDX_BAL_SET, IDX_BAL_LIMIT, IDX_BAL_HYST, IDX_ERR_CODE, IDX_CMD_WORD, IDX_IRQ_MASK,
                           IDX_BOOT_VER, IDX_BOOT_BUS, IDX_BOOT_HWGRP, IDX_SERIAL, IDX_DEVICE_ID};
  logic [31:0] re [11] = '{RST_BAL_SET, RST_BAL_LIMIT, RST_BAL_HYST, 32'h0, 32'h0, 32'h0,
                           V_BOOT, V_BUS, V_HW, V_SER, V_DID};

  // ==========================================================================
  // Design and master
  dorb_reg_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cond_in(cond),
    .boot_version_in(V_BOOT), .boot_fieldbus_in(V_BUS), .boot_hwgroup_in(V_HW), .serial_in(V_SER),
    .device_id_in(V_DID), .err_push(err_push), .err_entry(err_entry), .rxpdo_cmd_valid(pdo_v),
    .rxpdo_cmd_word(pdo_w), .cmd_word(cmd_word), .ballast_on(ballast_on), .txpdo(txpdo), .irq(irq));
  dorb_axi_master m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ==========================================================================
  // Compare and access helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s resp expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] e);
    m.rd(idx, rv, rr);
    if (m.timeouts != 0) wrap_up();
    chk(nm, e, rv);
    chk_resp(nm, RESP_OKAY, rr);
  endtask
  task automatic wrc(input string nm, input logic [15:0] idx, input logic [31:0] d, input logic [1:0] e);
    m.wr(idx, d, rr);
    if (m.timeouts != 0) wrap_up();
    chk_resp(nm, e, rr);
  endtask
  task automatic supply(input int mv);
    @(posedge aclk);
    cond.supply_mv <= mv;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wrap_up;
    miscompares += m.timeouts;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    cond = '{32'sd24000, -32'sd5000, 32'sd253};
    {err_push, err_entry, pdo_v, pdo_w} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rdc("preset", ri[i], re[i]);
    rdc("supply", IDX_SUPPLY_MV, 32'd24000);
    rdc("logic", IDX_LOGIC_MV, 32'hffff_ec78);
    rdc("temp", IDX_BOARD_TEMP, 32'd253);
    chk("txpdo supply", 32'd24000, txpdo.cond.supply_mv);
    chk("txpdo logic", 32'hffff_ec78, txpdo.cond.logic_mv);
    chk("txpdo temp", 32'd253, txpdo.cond.board_temp_dc);
    $display("test presets done");
    supply(50000);
    chk("ballast on", 1, ballast_on);
    supply(48700);
    chk("ballast hyst", 1, ballast_on);
    supply(48600);
    chk("ballast off", 0, ballast_on);
    rdc("status", IDX_IRQ_STAT, 32'h3);
    rdc("status clr", IDX_IRQ_STAT, 32'h0);
    $display("test ballast done");
    wrc("mask", IDX_IRQ_MASK, 32'h4, RESP_OKAY);
    @(posedge aclk);
    err_push <= 1'b1;
    err_entry <= 32'h1234_5678;
    @(posedge aclk);
    err_push <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq set", 1, irq);
    rdc("err code", IDX_ERR_CODE, 32'h5678);
    chk("txpdo err", 32'h5678, txpdo.error_code);
    rdc("status err", IDX_IRQ_STAT, 32'h4);
    repeat (2) @(posedge aclk);
    chk("irq clr", 0, irq);
    $display("test error done");
    @(posedge aclk);
    pdo_v <= 1'b1;
    pdo_w <= 16'h000f;
    @(posedge aclk);
    pdo_v <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pdo cmd", 32'h000f, cmd_word);
    wrc("cmd clr", IDX_CMD_WORD, 32'h0000_000b, RESP_OKAY);
    rdc("cmd clr", IDX_CMD_WORD, 32'h000b);
    wrc("cmd set", IDX_CMD_WORD, 32'h0000_000f, RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk("cmd kept", 32'h000f, cmd_word);
    irq_quiet: chk("irq masked", 0, irq);
    $display("test command done");
    wrc("ro boot", IDX_BOOT_VER, 32'h0, RESP_SLVERR);
    rdc("ro boot", IDX_BOOT_VER, V_BOOT);
    wrc("ro err", IDX_ERR_CODE, 32'hffff, RESP_SLVERR);
    rdc("ro err", IDX_ERR_CODE, 32'h5678);
    wrc("unmapped", 16'h4200, 32'h1, RESP_SLVERR);
    m.rd(16'h4200, rv, rr);
    if (m.timeouts != 0) wrap_up();
    chk("unmapped", 32'h0, rv);
    chk_resp("unmapped", RESP_SLVERR, rr);
    wrc("ro serial", IDX_SERIAL, 32'h0, RESP_SLVERR);
    rdc("ro serial", IDX_SERIAL, V_SER);
    wrc("ro id", IDX_DEVICE_ID, 32'h0, RESP_SLVERR);
    rdc("ro id", IDX_DEVICE_ID, V_DID);
    $display("test refusals done");
    wrc("limit", IDX_BAL_LIMIT, 32'h0000_ea60, RESP_OKAY);
    wrc("hyst", IDX_BAL_HYST, 32'h0000_0064, RESP_OKAY);
    rdc("limit", IDX_BAL_LIMIT, 32'h0000_ea60);
    rdc("hyst", IDX_BAL_HYST, 32'h0000_0064);
    supply(60000);
    chk("at limit", 0, ballast_on);
    supply(60001);
    chk("above limit", 1, ballast_on);
    rdc("bal state", IDX_BAL_STATE, 32'h1);
    wrc("disable", IDX_BAL_SET, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("disabled", 0, ballast_on);
    rdc("settings", IDX_BAL_SET, 32'h0);
    $display("test ballast config done");
    wrap_up();
  end
endmodule // tb_drive_object_register_bank
